/* hdl/qdlrc_pkg.sv */
// Shared constants and types for the quad converter load and reset control block.
package qdlrc_pkg;
    localparam int          CODE_W        = 12;
    localparam int          NUM_CH        = 4;
    localparam int          NUM_GPIO      = 2;
    localparam int          WORD_W        = 24;
    localparam int          ADDR_MSB      = 19;
    localparam int          ADDR_LSB      = 16;
    localparam int          DATA_MSB      = 15;
    localparam int          DATA_LSB      = 4;
    localparam logic [1:0]  SEL_DATA      = 2'h0;
    localparam logic [1:0]  SEL_ZERO      = 2'h2;
    localparam logic [1:0]  SEL_GAIN      = 2'h3;
    localparam logic [11:0] IN_DEFAULT    = 12'h000;
    localparam logic [11:0] ZERO_DEFAULT  = 12'h000;
    localparam logic [11:0] GAIN_DEFAULT  = 12'h000;
    localparam logic [11:0] BIPOLAR_FLIP  = 12'h800;
    localparam logic [11:0] UNIPOLAR_FLIP = 12'h000;
    localparam logic [1:0]  GROUP_A_MASK  = 2'h3;

    typedef logic [CODE_W-1:0]             qdlrc_code_t;
    typedef logic [NUM_CH-1:0][CODE_W-1:0] qdlrc_bank_t;
endpackage : qdlrc_pkg

/* hdl/qdlrc_ser_if.sv */
// Carrier between the serial receiver and the control core.
`timescale 1ns/10ps
interface qdlrc_ser_if;
    logic [qdlrc_pkg::WORD_W-1:0] word;

    modport rx   (output word);
    modport core (input word);
endinterface : qdlrc_ser_if

/* hdl/qdlrc_serial_rx.sv */
// Serial input shift register running on the host serial clock.
`timescale 1ns/10ps
module qdlrc_serial_rx (
    input  wire logic  sclk,
    input  wire logic  cs_n,
    input  wire logic  sdi,
    output logic       sdo,
    output logic       sdo_oe,
    qdlrc_ser_if.rx    ser
);
    import qdlrc_pkg::*;

    typedef struct packed {
        logic [WORD_W-1:0] shift;
    } qdlrc_rx_state_t;

    qdlrc_rx_state_t st_reg;
    qdlrc_rx_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (!cs_n) begin
            st_next.shift = {st_reg.shift[WORD_W-2:0], sdi};
        end
    end

    // The shifter holds its data while select is high, so it is stable for the core to read.
    always_ff @(posedge sclk) begin
        st_reg <= st_next;
    end

    assign ser.word = st_reg.shift;
    assign sdo      = st_reg.shift[WORD_W-1];
    assign sdo_oe   = ~cs_n;
endmodule : qdlrc_serial_rx

/* hdl/qdlrc_top.sv */
// Load, reset and polarity control core of the quad converter, with serial receiver attached.
// Summary of operation
// - Serial bits shift in only while chip select is low for the whole transfer.
// - Serial data output floats whenever chip select is high.
// - Load input low makes each latch follow its input data register.
// - Converter output codes come straight from the latches, no extra stage.
// - Reset pin low forces input registers to the default code and latches to its strap-converted code.
// - Reset pin low also restores all gain and zero calibration registers.
// - General-purpose pins read as inputs and only ever pull low as outputs.
// - Group A strap high means unipolar, low means bipolar for channels zero, one.
// - Codes are straight binary when unipolar and twos complement when bipolar.
`timescale 1ns/10ps
module qdlrc_top (
    input  wire logic                 mclk,
    input  wire logic                 sys_rst,
    input  wire logic                 sclk,
    input  wire logic                 cs_n,
    input  wire logic                 sdi,
    output logic                      sdo,
    output logic                      sdo_oe,
    input  wire logic                 latch_load_n,
    input  wire logic                 reset_n,
    input  wire logic                 polarity_strap_group_a,
    input  wire logic [1:0]           gpio_i,
    output logic      [1:0]           gpio_o,
    output logic      [1:0]           gpio_oe,
    input  wire logic [1:0]           gpio_pull_low,
    output logic      [1:0]           gpio_level,
    output qdlrc_pkg::qdlrc_bank_t    dac_code,
    output qdlrc_pkg::qdlrc_bank_t    gain_cal,
    output qdlrc_pkg::qdlrc_bank_t    zero_cal,
    output logic                      unipolar_a
);
    import qdlrc_pkg::*;

    typedef struct packed {
        logic              cs_s1;
        logic              cs_s2;
        logic              cs_prev;
        logic              ld_s1;
        logic              ld_s2;
        logic              rst_s1;
        logic              rst_s2;
        logic              pol_s1;
        logic              pol_s2;
        logic [1:0]        gp_s1;
        logic [1:0]        gp_s2;
        logic [1:0]        gp_pull;
        logic              unipolar;
        qdlrc_bank_t       in_data;
        qdlrc_bank_t       latch;
        qdlrc_bank_t       gain;
        qdlrc_bank_t       zero;
    } qdlrc_state_t;

    qdlrc_state_t st_reg;
    qdlrc_state_t st_next;

    qdlrc_ser_if ser ();

    qdlrc_serial_rx u_rx (
        .sclk   (sclk),
        .cs_n   (cs_n),
        .sdi    (sdi),
        .sdo    (sdo),
        .sdo_oe (sdo_oe),
        .ser    (ser)
    );

    logic [1:0]      word_ch;
    logic [1:0]      word_sel;
    qdlrc_code_t     word_data;
    logic            frame_end;

    assign word_ch   = ser.word[ADDR_LSB+1:ADDR_LSB];
    assign word_sel  = ser.word[ADDR_MSB:ADDR_LSB+2];
    assign word_data = ser.word[DATA_MSB:DATA_LSB];
    // The shifter is read only after select has risen and crossed two stages, so it no longer moves.
    assign frame_end = st_reg.cs_s2 & ~st_reg.cs_prev;

    // Flips the sign bit of bipolar group A codes so the analog core always sees offset binary.
    // The group mask is widened to every channel so group B indexes a defined zero bit, never an unknown.
    function automatic qdlrc_code_t conv(input int unsigned ch, input logic uni, input qdlrc_code_t c);
        logic [NUM_CH-1:0] grp_a;
        qdlrc_code_t       flip;
        grp_a = NUM_CH'(GROUP_A_MASK);
        flip  = (grp_a[ch[1:0]] && !uni) ? BIPOLAR_FLIP : UNIPOLAR_FLIP;
        return c ^ flip;
    endfunction : conv

    always_comb begin
        st_next          = st_reg;
        st_next.cs_s1    = cs_n;
        st_next.cs_s2    = st_reg.cs_s1;
        st_next.cs_prev  = st_reg.cs_s2;
        st_next.ld_s1    = latch_load_n;
        st_next.ld_s2    = st_reg.ld_s1;
        st_next.rst_s1   = reset_n;
        st_next.rst_s2   = st_reg.rst_s1;
        st_next.pol_s1   = polarity_strap_group_a;
        st_next.pol_s2   = st_reg.pol_s1;
        st_next.gp_s1    = gpio_i;
        st_next.gp_s2    = st_reg.gp_s1;
        st_next.gp_pull  = gpio_pull_low;
        st_next.unipolar = st_reg.pol_s2;

        if (frame_end) begin
            case (word_sel)
                SEL_DATA: st_next.in_data[word_ch] = word_data;
                SEL_ZERO: st_next.zero[word_ch]    = word_data;
                SEL_GAIN: st_next.gain[word_ch]    = word_data;
                default:  st_next.in_data          = st_reg.in_data;
            endcase
        end

        for (int i = 0; i < NUM_CH; i++) begin
            if (!st_reg.ld_s2) begin
                st_next.latch[i] = conv(i, st_reg.unipolar, st_reg.in_data[i]);
            end else begin
                st_next.latch[i] = st_reg.latch[i];
            end
        end

        if (!st_reg.rst_s2) begin
            for (int i = 0; i < NUM_CH; i++) begin
                st_next.in_data[i] = IN_DEFAULT;
                st_next.latch[i]   = conv(i, st_reg.unipolar, IN_DEFAULT);
                st_next.gain[i]    = GAIN_DEFAULT;
                st_next.zero[i]    = ZERO_DEFAULT;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_reg          <= '0;
            st_reg.cs_s1    <= 1'b1;
            st_reg.cs_s2    <= 1'b1;
            st_reg.cs_prev  <= 1'b1;
            st_reg.ld_s1    <= 1'b1;
            st_reg.ld_s2    <= 1'b1;
            st_reg.rst_s1   <= 1'b1;
            st_reg.rst_s2   <= 1'b1;
            // Strap and pin stages start at the idle high level so no false mode or edge follows reset.
            st_reg.pol_s1   <= 1'b1;
            st_reg.pol_s2   <= 1'b1;
            st_reg.gp_s1    <= 2'h3;
            st_reg.gp_s2    <= 2'h3;
            st_reg.unipolar <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dac_code   = st_reg.latch;
    assign gain_cal   = st_reg.gain;
    assign zero_cal   = st_reg.zero;
    assign unipolar_a = st_reg.unipolar;
    assign gpio_o     = 2'h0;
    assign gpio_oe    = st_reg.gp_pull;
    assign gpio_level = st_reg.gp_s2;
endmodule : qdlrc_top

/* tb/qdlrc_props.sv */
// Checker for the pin behaviour of the load and reset control block.
`timescale 1ns/10ps
module qdlrc_props (
    input logic                   mclk,
    input logic                   sys_rst,
    input logic                   cs_n,
    input logic                   sdo_oe,
    input logic                   latch_load_n,
    input logic                   reset_n,
    input logic                   polarity_strap_group_a,
    input logic [1:0]             gpio_pull_low,
    input logic [1:0]             gpio_o,
    input logic [1:0]             gpio_oe,
    input qdlrc_pkg::qdlrc_bank_t dac_code,
    input qdlrc_pkg::qdlrc_bank_t gain_cal,
    input qdlrc_pkg::qdlrc_bank_t zero_cal,
    input logic                   unipolar_a
);
    import qdlrc_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence ld_idle; (latch_load_n && reset_n) [*4]; endsequence
    sequence rst_held; (!reset_n) [*4]; endsequence
    a_sdo_release: assert property (sdo_oe == !cs_n)
        else $error("sdo enable does not follow select");
    a_gpio_drain: assert property (gpio_o == 2'h0)
        else $error("gpio drives high");
    a_gpio_pull: assert property (!$past(sys_rst) |-> gpio_oe == $past(gpio_pull_low))
        else $error("gpio enable wrong");
    a_load_hold: assert property (ld_idle |-> $stable(dac_code))
        else $error("latch moved while load high");
    a_reset_cal: assert property (rst_held |-> gain_cal == {NUM_CH{GAIN_DEFAULT}} && zero_cal == {NUM_CH{ZERO_DEFAULT}})
        else $error("calibration not reset");
    a_reset_dac: assert property (rst_held |-> dac_code[3] == IN_DEFAULT &&
        dac_code[0] == ($past(unipolar_a) ? IN_DEFAULT : (IN_DEFAULT ^ BIPOLAR_FLIP)))
        else $error("latch not reset");
    a_strap_mode: assert property ($stable(polarity_strap_group_a) [*4] |-> unipolar_a == polarity_strap_group_a)
        else $error("mode does not follow strap");
    a_cal_quiet: assert property ((cs_n && reset_n) [*6] |-> $stable(gain_cal) && $stable(zero_cal))
        else $error("calibration changed outside frame");
endmodule : qdlrc_props
bind qdlrc_top qdlrc_props u_props (.*);

/* tb/qdlrc_host_model.sv */
// Serial host that sends one word per frame.
`timescale 1ns/10ps
module qdlrc_host_model (
    output logic sclk,
    output logic cs_n,
    output logic sdi
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    task send(input logic [23:0] w);
        #1.7 cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdi = w[i];
            #3.0 sclk = 1'b1;
            #3.0 sclk = 1'b0;
        end
        sdi = ~sdi;
        #3.0 cs_n = 1'b1;
        #40.0;
    endtask : send
endmodule : qdlrc_host_model

/* tb/qdlrc_tb_top.sv */
// Self-checking bench for the load and reset control block.
`timescale 1ns/10ps
module quad_dac_load_reset_control_tb_top;
    import qdlrc_pkg::*;
    logic        sclk, cs_n, sdi, sdo, sdo_oe, unipolar_a;
    logic        mclk = 1'b0, sys_rst = 1'b1, ld_n = 1'b1, rst_n = 1'b1, strap = 1'b1;
    logic [1:0]  pull = 2'h0, gpio_o, gpio_oe, gpio_level;
    wire  [1:0]  gpio_pin = (gpio_oe & gpio_o) | ~gpio_oe;
    qdlrc_bank_t dac_code, gain_cal, zero_cal;
    int          err_total = 0, compares = 0;
    always #4.0 mclk = ~mclk;
    qdlrc_host_model host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi));
    qdlrc_top DUT (.mclk(mclk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe(sdo_oe), .latch_load_n(ld_n), .reset_n(rst_n), .polarity_strap_group_a(strap),
        .gpio_i(gpio_pin), .gpio_o(gpio_o), .gpio_oe(gpio_oe), .gpio_pull_low(pull),
        .gpio_level(gpio_level), .dac_code(dac_code), .gain_cal(gain_cal), .zero_cal(zero_cal),
        .unipolar_a(unipolar_a));
    task chk(input qdlrc_code_t seen, input qdlrc_code_t exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task stop_test;
        $display("compares %0d, err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    task cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    task wr(input logic [1:0] sel, input logic [1:0] ch, input qdlrc_code_t code);
        host.send({4'h0, sel, ch, code, 4'h0});
        cyc(6);
    endtask : wr
    initial begin
        #100000;
        err_total++;
        stop_test;
    end
    initial begin
        cyc(20);
        sys_rst = 1'b0;
        cyc(4);
        chk(dac_code[1], IN_DEFAULT);
        chk(qdlrc_code_t'(unipolar_a), 12'h001);
        pull = 2'h2;
        cyc(3);
        chk(qdlrc_code_t'(gpio_level), 12'h001);
        chk(qdlrc_code_t'(gpio_oe), 12'h002);
        chk(qdlrc_code_t'(gpio_o), 12'h000);
        wr(SEL_GAIN, 2'h1, 12'hABC);
        chk(gain_cal[1], 12'hABC);
        wr(SEL_ZERO, 2'h2, 12'h123);
        chk(zero_cal[2], 12'h123);
        wr(2'h1, 2'h0, 12'h333);
        chk(gain_cal[0], GAIN_DEFAULT);
        wr(SEL_DATA, 2'h2, 12'h5A5);
        chk(dac_code[2], IN_DEFAULT);
        ld_n = 1'b0;
        cyc(2);
        chk(dac_code[2], IN_DEFAULT);
        cyc(1);
        chk(dac_code[2], 12'h5A5);
        wr(SEL_DATA, 2'h3, 12'h777);
        chk(dac_code[3], 12'h777);
        ld_n = 1'b1;
        strap = 1'b0;
        wr(SEL_DATA, 2'h0, 12'hFFF);
        chk(qdlrc_code_t'(unipolar_a), 12'h000);
        ld_n = 1'b0;
        cyc(4);
        ld_n = 1'b1;
        chk(dac_code[0], 12'h7FF);
        chk(dac_code[1], 12'h800);
        chk(dac_code[2], 12'h5A5);
        host.send(24'h8C0AB0);
        cyc(6);
        chk(gain_cal[0], 12'h0AB);
        chk(qdlrc_code_t'(sdo), 12'h001);
        rst_n = 1'b0;
        cyc(5);
        chk(gain_cal[1], GAIN_DEFAULT);
        chk(zero_cal[2], ZERO_DEFAULT);
        chk(dac_code[0], 12'h800);
        chk(gain_cal[0], GAIN_DEFAULT);
        rst_n = 1'b1;
        cyc(3);
        chk(qdlrc_code_t'(sdo_oe), 12'h000);
        stop_test;
    end
endmodule : quad_dac_load_reset_control_tb_top
